// ---- hdl/ssp_consts.svh ----
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
`define SSP_ADDR_W 5
`define SSP_DATA_W 16

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SSP_OFS_TRANSMIT_DATA 5'h00
`define SSP_OFS_RECEIVE_DATA 5'h02
`define SSP_OFS_CONTROL_AND_STATUS 5'h04
`define SSP_OFS_SECOND_CONTROL 5'h06
`define SSP_OFS_TRANSMIT_CONTROL 5'h08
`define SSP_OFS_RECEIVE_CONTROL 5'h0a
`define SSP_OFS_TIME_SLOT 5'h0c
`define SSP_OFS_FIFO_CONTROL_STATUS 5'h0e
`define SSP_OFS_TEST_CONTROL 5'h10
`define SSP_OFS_OPTION_CONTROL 5'h12
`define SSP_OFS_TX_SLOT_MASK_LOW 5'h14
`define SSP_OFS_TX_SLOT_MASK_HIGH 5'h16
`define SSP_OFS_RX_SLOT_MASK_LOW 5'h18
`define SSP_OFS_RX_SLOT_MASK_HIGH 5'h1a
`define SSP_OFS_FRAME_STATUS 5'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSP_CS_TX_EMPTY 0
`define SSP_CS_RX_FULL 1
`define SSP_CS_RX_OVERRUN 2
`define SSP_CS_TX_UNDERRUN 3
`define SSP_CS_LOCKED 4
`define SSP_CS_SHARED_TIMING 8
`define SSP_SC2_SHIFT_ORDER 0
`define SSP_SC2_NETWORK 1
`define SSP_SC2_HALF_MSB 15
`define SSP_SC2_HALF_LSB 8
`define SSP_TXC_DC_MSB 4
`define SSP_TXC_DC_LSB 0
`define SSP_TXC_WL_MSB 6
`define SSP_TXC_WL_LSB 5
`define SSP_TXC_PORT_ENABLE 7
`define SSP_TXC_TX_CLOCK_DIR 8
`define SSP_TXC_FRAME_WORD 9
`define SSP_TXC_FRAME_EARLY 10
`define SSP_RXC_RX_CLOCK_DIR 8
`define SSP_SOR_TX_FRAME_DIR 0
`define SSP_SOR_RX_FRAME_DIR 1

// ----------------------------------------------------------------
// word length codes and last bit index
// ----------------------------------------------------------------
`define SSP_WL_8 2'h0
`define SSP_WL_10 2'h1
`define SSP_WL_12 2'h2
`define SSP_WL_16 2'h3
`define SSP_LAST_8 4'h7
`define SSP_LAST_10 4'h9
`define SSP_LAST_12 4'hb
`define SSP_LAST_16 4'hf

// ----------------------------------------------------------------
// synchroniser width: bit clock, frame pulse, serial in
// ----------------------------------------------------------------
`define SSP_SYNC_W 3

`endif

// ---- hdl/ssp_pkg.sv ----
package ssp_pkg;

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic {SSP_IDLE, SSP_RUN} ssp_state_e;

  // ----------------------------------------------------------------
  // port state
  // ----------------------------------------------------------------
  typedef struct packed {
    ssp_state_e state;
    logic [15:0] tx_data;
    logic tx_full;
    logic [15:0] tx_word;
    logic tx_act;
    logic ser_out;
    logic tue;
    logic [15:0] rx_data;
    logic [15:0] rx_shift;
    logic rdf;
    logic roe;
    logic syn;
    logic [15:0] ctrl2;
    logic [15:0] txc;
    logic [15:0] rxc;
    logic [15:0] fifo_cs;
    logic [15:0] test_c;
    logic [15:0] opt;
    logic [31:0] tmask;
    logic [31:0] rmask;
    logic [15:0] rdata;
    logic [3:0] cnt;
    logic [4:0] slot;
    logic locked;
    logic pend_align;
    logic sck_prev;
    logic fs_prev;
    logic fs_out;
  } ssp_top_s;

  // ----------------------------------------------------------------
  // bit clock generator state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cnt;
    logic sck;
    logic rise;
    logic fall;
  } ssp_clk_s;

endpackage : ssp_pkg

// ---- hdl/ssp_bit_if.sv ----
`timescale 1ns/1ps

// internal bit clock level and its edge pulses
interface ssp_bit_if;
  logic sck;
  logic rise;
  logic fall;
  modport gen (output sck, output rise, output fall);
  modport sink (input sck, input rise, input fall);
endinterface : ssp_bit_if

// ---- hdl/ssp_sync2.sv ----
`timescale 1ns/1ps

module ssp_sync2 #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssp_sync_s;

  ssp_sync_s st_reg;
  ssp_sync_s st_next;

  // meta feeds only the second stage
  always_comb begin
    st_next.meta = async_in;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stable;

endmodule : ssp_sync2

// ---- hdl/ssp_clkgen.sv ----
`timescale 1ns/1ps

module ssp_clkgen
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [7:0] half,
  // generated bit clock
  ssp_bit_if.gen bits
);

  ssp_clk_s st_reg;
  ssp_clk_s st_next;

  // stopped means low, so a gated burst always starts from rest
  always_comb begin
    st_next = st_reg;
    st_next.rise = 1'b0;
    st_next.fall = 1'b0;
    if (!run) begin
      st_next.cnt = 8'h00;
      st_next.sck = 1'b0;
    end else if (st_reg.cnt == half) begin
      st_next.cnt = 8'h00;
      st_next.sck = ~st_reg.sck;
      st_next.rise = ~st_reg.sck;
      st_next.fall = st_reg.sck;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bits.sck = st_reg.sck;
  assign bits.rise = st_reg.rise;
  assign bits.fall = st_reg.fall;

endmodule : ssp_clkgen

// ---- hdl/ssp_sync_serial_port.sv ----
// Notes on behaviour
// - only shared timing: receive runs on the transmit clock and frame pulse
// - transmit bit clock and frame pulse pins serve both directions
// - receive clock and frame pins are unused and released to general io
// - gated mode: clock toggles only during a word, rests low otherwise
// - gated mode uses no frame pulse; frame pins are released
// - frame pulse is one bit long or one word long, as configured
// - frame pulse starts one bit early or with the first data bit
// - serial out is driven only while a word shifts, else released
// - serial out released after reset since port enable resets low
// - clock and frame pins are inputs after reset
// - clock dir, frame dir and shared select high, rx clock dir low: device drives both
// - both directions low, shared select high: far end drives clock and frame
// - rx and tx clock dirs high with shared select: device drives gated clock
// - word length is 8, 10, 12 or 16 bits
// - network mode shares the port over up to thirty-two slots
// - transmit data write only, receive data read only, shifters unmapped
// - word length code 00, 01, 10, 11 selects 8, 10, 12, 16 bits
// - shift order bit picks msb or lsb first; words left-justified
// - received short words have their low unused bits zero
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "ssp_consts.svh"

module ssp_sync_serial_port
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [`SSP_ADDR_W-1:0] reg_addr,
  input wire logic [`SSP_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`SSP_DATA_W-1:0] reg_rdata,
  // shared bit clock pin
  input wire logic tx_bit_clock_pin_level,
  output logic tx_bit_clock_pin_drive,
  output logic tx_bit_clock_pin_oe,
  // shared frame pulse pin
  input wire logic tx_frame_pulse_pin_level,
  output logic tx_frame_pulse_pin_drive,
  output logic tx_frame_pulse_pin_oe,
  // serial data pins
  output logic serial_out_pin_drive,
  output logic serial_out_pin_oe,
  input wire logic serial_in_pin,
  // pins handed to general io: {frame pins, rx frame pin, rx clock pin}
  output logic [2:0] pins_released
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  ssp_top_s st_reg;
  ssp_top_s st_next;
  ssp_bit_if bit_bus ();

  logic enabled;
  logic gated;
  logic int_clk;
  logic int_fs;
  logic fs_word;
  logic fs_early;
  logic lsb_first;
  logic network;
  logic [3:0] wl_m1;
  logic [4:0] dc;
  logic [`SSP_SYNC_W-1:0] pins_sync;
  logic sck_s;
  logic fs_s;
  logic rx_s;
  logic bit_rise;
  logic bit_fall;
  logic clk_run;

  // engine scratch, assigned at the top of the comb process
  logic [3:0] cnt_n;
  logic [4:0] slot_n;
  logic [3:0] cnt_s;
  logic [4:0] slot_s;
  logic [15:0] rx_word;
  logic rx_done;
  logic roe_set;
  logic tue_set;
  logic fs_start;
  logic first_bit;
  logic last_bit;

  // no shared select means no timing at all: async mode is absent
  assign enabled = st_reg.txc[`SSP_TXC_PORT_ENABLE] & st_reg.syn;
  assign int_clk = st_reg.txc[`SSP_TXC_TX_CLOCK_DIR];
  assign gated = int_clk & st_reg.rxc[`SSP_RXC_RX_CLOCK_DIR];
  assign int_fs = st_reg.opt[`SSP_SOR_TX_FRAME_DIR];
  assign fs_word = st_reg.txc[`SSP_TXC_FRAME_WORD];
  assign fs_early = st_reg.txc[`SSP_TXC_FRAME_EARLY];
  assign lsb_first = st_reg.ctrl2[`SSP_SC2_SHIFT_ORDER];
  assign network = st_reg.ctrl2[`SSP_SC2_NETWORK];
  assign dc = st_reg.txc[`SSP_TXC_DC_MSB:`SSP_TXC_DC_LSB];

  // word length decode
  always_comb begin
    case (st_reg.txc[`SSP_TXC_WL_MSB:`SSP_TXC_WL_LSB])
      `SSP_WL_8: wl_m1 = `SSP_LAST_8;
      `SSP_WL_10: wl_m1 = `SSP_LAST_10;
      `SSP_WL_12: wl_m1 = `SSP_LAST_12;
      `SSP_WL_16: wl_m1 = `SSP_LAST_16;
      default: wl_m1 = `SSP_LAST_16;
    endcase
  end

  // position of bit number c within the left-justified word
  function automatic logic [3:0] bit_index(input logic [3:0] c, input logic [3:0] last, input logic lsb);
    bit_index = lsb ? (4'hf - last + c) : (4'hf - c);
  endfunction : bit_index

  // slot filter; outside network mode every word is taken
  function automatic logic slot_open(input logic [31:0] mask, input logic [4:0] s, input logic net);
    slot_open = ~net | ~mask[s];
  endfunction : slot_open

  // ----------------------------------------------------------------
  // pin synchronisers and bit timing source
  // ----------------------------------------------------------------
  ssp_sync2 #(
    .W(`SSP_SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({serial_in_pin, tx_frame_pulse_pin_level, tx_bit_clock_pin_level}),
    .sync_out(pins_sync)
  );

  assign sck_s = pins_sync[0];
  assign fs_s = pins_sync[1];
  assign rx_s = pins_sync[2];

  // gated bursts stop the generator between words
  assign clk_run = enabled & int_clk & (~gated | (st_reg.state == SSP_RUN));

  ssp_clkgen u_clkgen (
    .clk(clk),
    .rst(rst),
    .run(clk_run),
    .half(st_reg.ctrl2[`SSP_SC2_HALF_MSB:`SSP_SC2_HALF_LSB]),
    .bits(bit_bus)
  );

  // one clock edge source drives both directions
  assign bit_rise = enabled & (int_clk ? bit_bus.rise : (sck_s & ~st_reg.sck_prev));
  assign bit_fall = enabled & (int_clk ? bit_bus.fall : (~sck_s & st_reg.sck_prev));

  // ----------------------------------------------------------------
  // serial engine and register port
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    cnt_n = st_reg.cnt;
    slot_n = st_reg.slot;
    cnt_s = st_reg.cnt;
    slot_s = st_reg.slot;
    rx_word = st_reg.rx_shift;
    rx_done = 1'b0;
    roe_set = 1'b0;
    tue_set = 1'b0;
    fs_start = 1'b0;
    first_bit = 1'b0;
    last_bit = 1'b0;
    st_next.sck_prev = sck_s;
    if (!enabled) begin
      // park counters so the first rise opens bit 0 of slot 0
      st_next.state = SSP_IDLE;
      st_next.cnt = 4'hf;
      st_next.slot = dc;
      st_next.locked = 1'b0;
      st_next.pend_align = 1'b0;
      st_next.tx_act = 1'b0;
      st_next.fs_out = 1'b0;
      st_next.fs_prev = 1'b0;
    end else begin
      if (int_fs || gated) begin
        st_next.locked = 1'b1;
      end
      // a gated burst starts only when a word is waiting
      if (gated && st_reg.state == SSP_IDLE && st_reg.tx_full) begin
        st_next.state = SSP_RUN;
      end
      // rising edge: next bit starts, output changes
      if (bit_rise) begin
        if (st_reg.pend_align || st_reg.cnt >= wl_m1) begin
          cnt_n = 4'h0;
          if (st_reg.pend_align || gated || st_reg.slot == dc) begin
            slot_n = 5'h00;
          end else begin
            slot_n = st_reg.slot + 5'h01;
          end
        end else begin
          cnt_n = st_reg.cnt + 4'h1;
        end
        st_next.cnt = cnt_n;
        st_next.slot = slot_n;
        st_next.pend_align = 1'b0;
        if (st_reg.pend_align) begin
          st_next.locked = 1'b1;
        end
        if (cnt_n == 4'h0) begin
          st_next.tx_act = 1'b0;
          if ((st_reg.locked || st_reg.pend_align) && slot_open(st_reg.tmask, slot_n, network)) begin
            if (st_reg.tx_full) begin
              st_next.tx_word = st_reg.tx_data;
              st_next.tx_full = 1'b0;
              st_next.tx_act = 1'b1;
            end else begin
              tue_set = 1'b1;
            end
          end
        end
        st_next.ser_out = st_next.tx_word[bit_index(cnt_n, wl_m1, lsb_first)];
        // device-made frame pulse, level changes with the bit
        first_bit = (cnt_n == 4'h0) && (slot_n == 5'h00);
        last_bit = (cnt_n == wl_m1) && (slot_n == dc);
        if (int_fs && !gated) begin
          if (fs_word) begin
            st_next.fs_out = fs_early ? (((slot_n == 5'h00) && (cnt_n != wl_m1)) || last_bit)
                                      : (slot_n == 5'h00);
          end else begin
            st_next.fs_out = fs_early ? last_bit : first_bit;
          end
        end
      end
      // falling edge: sample input, follow the far end's frame pulse
      if (bit_fall) begin
        if (!int_fs && !gated) begin
          fs_start = fs_s & ~st_reg.fs_prev;
          st_next.fs_prev = fs_s;
        end
        if (fs_start && fs_early) begin
          st_next.pend_align = 1'b1;
        end else if (fs_start) begin
          // a misaligned word was never started at the right edge; drop it
          if (st_reg.cnt != 4'h0 || st_reg.slot != 5'h00) begin
            st_next.tx_act = 1'b0;
          end
          cnt_s = 4'h0;
          slot_s = 5'h00;
          st_next.cnt = 4'h0;
          st_next.slot = 5'h00;
          st_next.locked = 1'b1;
        end
        if ((st_reg.locked || (fs_start && !fs_early)) && slot_open(st_reg.rmask, slot_s, network)) begin
          if (cnt_s == 4'h0) begin
            rx_word = 16'h0000;
          end
          rx_word[bit_index(cnt_s, wl_m1, lsb_first)] = rx_s;
          st_next.rx_shift = rx_word;
          if (cnt_s == wl_m1) begin
            st_next.rx_data = rx_word;
            st_next.rdf = 1'b1;
            rx_done = 1'b1;
            roe_set = st_reg.rdf;
          end
        end
        if (gated && cnt_s == wl_m1) begin
          st_next.state = SSP_IDLE;
          st_next.tx_act = 1'b0;
        end
      end
    end
    if (roe_set) begin
      st_next.roe = 1'b1;
    end
    if (tue_set) begin
      st_next.tue = 1'b1;
    end
    // reads: data stands for one cycle; a new event wins over a clear
    st_next.rdata = 16'h0000;
    if (reg_read) begin
      case (reg_addr)
        `SSP_OFS_RECEIVE_DATA: begin
          st_next.rdata = st_reg.rx_data;
          st_next.rdf = rx_done;
          st_next.roe = roe_set;
        end
        `SSP_OFS_CONTROL_AND_STATUS: begin
          st_next.rdata = {7'h00, st_reg.syn, 3'h0, st_reg.locked, st_reg.tue, st_reg.roe, st_reg.rdf,
                           ~st_reg.tx_full};
        end
        `SSP_OFS_SECOND_CONTROL: st_next.rdata = st_reg.ctrl2;
        `SSP_OFS_TRANSMIT_CONTROL: st_next.rdata = st_reg.txc;
        `SSP_OFS_RECEIVE_CONTROL: st_next.rdata = st_reg.rxc;
        `SSP_OFS_FIFO_CONTROL_STATUS: st_next.rdata = st_reg.fifo_cs;
        `SSP_OFS_TEST_CONTROL: st_next.rdata = st_reg.test_c;
        `SSP_OFS_OPTION_CONTROL: st_next.rdata = st_reg.opt;
        `SSP_OFS_TX_SLOT_MASK_LOW: st_next.rdata = st_reg.tmask[15:0];
        `SSP_OFS_TX_SLOT_MASK_HIGH: st_next.rdata = st_reg.tmask[31:16];
        `SSP_OFS_RX_SLOT_MASK_LOW: st_next.rdata = st_reg.rmask[15:0];
        `SSP_OFS_RX_SLOT_MASK_HIGH: st_next.rdata = st_reg.rmask[31:16];
        `SSP_OFS_FRAME_STATUS: st_next.rdata = {11'h000, st_reg.slot};
        default: st_next.rdata = 16'h0000; // write-only and unmapped read zero
      endcase
    end
    // writes: a word written while one is loaded replaces it; the loaded word is lost
    if (reg_write) begin
      case (reg_addr)
        `SSP_OFS_TRANSMIT_DATA: begin
          st_next.tx_data = reg_wdata;
          st_next.tx_full = 1'b1;
          st_next.tue = tue_set;
        end
        `SSP_OFS_CONTROL_AND_STATUS: st_next.syn = reg_wdata[`SSP_CS_SHARED_TIMING];
        `SSP_OFS_SECOND_CONTROL: st_next.ctrl2 = reg_wdata;
        `SSP_OFS_TRANSMIT_CONTROL: st_next.txc = reg_wdata;
        `SSP_OFS_RECEIVE_CONTROL: st_next.rxc = reg_wdata;
        `SSP_OFS_FIFO_CONTROL_STATUS: st_next.fifo_cs = reg_wdata;
        `SSP_OFS_TEST_CONTROL: st_next.test_c = reg_wdata;
        `SSP_OFS_OPTION_CONTROL: st_next.opt = reg_wdata;
        `SSP_OFS_TX_SLOT_MASK_LOW: st_next.tmask[15:0] = reg_wdata;
        `SSP_OFS_TX_SLOT_MASK_HIGH: st_next.tmask[31:16] = reg_wdata;
        `SSP_OFS_RX_SLOT_MASK_LOW: st_next.rmask[15:0] = reg_wdata;
        `SSP_OFS_RX_SLOT_MASK_HIGH: st_next.rmask[31:16] = reg_wdata;
        default: st_next.rdata = st_next.rdata; // time slot, read-only, unmapped: no effect
      endcase
    end
  end

  // all control state clears, so pins start as inputs and only the rx clock and rx frame pins released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st_reg.rdata;
  assign tx_bit_clock_pin_drive = bit_bus.sck;
  assign tx_bit_clock_pin_oe = int_clk;
  assign tx_frame_pulse_pin_drive = st_reg.fs_out;
  assign tx_frame_pulse_pin_oe = int_fs & ~gated;
  assign serial_out_pin_drive = st_reg.ser_out;
  assign serial_out_pin_oe = st_reg.tx_act;
  assign pins_released = {gated, 1'b1, 1'b1};

endmodule : ssp_sync_serial_port

// ---- verif/ssp_chk.sv ----
`timescale 1ns/1ps
`include "ssp_consts.svh"

module ssp_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [`SSP_ADDR_W-1:0] reg_addr,
  input wire logic [`SSP_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [`SSP_DATA_W-1:0] reg_rdata,
  // pins
  input wire logic tx_bit_clock_pin_drive,
  input wire logic tx_bit_clock_pin_oe,
  input wire logic tx_frame_pulse_pin_oe,
  input wire logic tx_frame_pulse_pin_drive,
  input wire logic serial_out_pin_drive,
  input wire logic serial_out_pin_oe,
  input wire logic [2:0] pins_released
);
  // ------------------------------------------------
  // port rules, one clock domain
  // ------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_txdata_wo: assert property (reg_read && reg_addr == `SSP_OFS_TRANSMIT_DATA |=> reg_rdata == 16'h0000)
    else $error("transmit data readable");
  a_out_reset: assert property ($fell(rst) |-> !serial_out_pin_oe && !tx_bit_clock_pin_oe && !tx_frame_pulse_pin_oe)
    else $error("pin driven after reset");
  a_rx_pins_free: assert property (pins_released[1:0] == 2'b11)
    else $error("rx frame pin not released");
  a_clk_dir: assert property (reg_write && reg_addr == `SSP_OFS_TRANSMIT_CONTROL |=>
    tx_bit_clock_pin_oe == $past(reg_wdata[8]))
    else $error("clock pin direction wrong");
  a_fs_dir: assert property (reg_write && reg_addr == `SSP_OFS_OPTION_CONTROL && !pins_released[2] |=>
    tx_frame_pulse_pin_oe == $past(reg_wdata[0]))
    else $error("frame pin direction wrong");
  a_gated_sel: assert property (reg_write && reg_addr == `SSP_OFS_RECEIVE_CONTROL && tx_bit_clock_pin_oe |=>
    pins_released[2] == $past(reg_wdata[8]))
    else $error("gated mode select wrong");
  a_fs_edge: assert property (tx_bit_clock_pin_oe && tx_frame_pulse_pin_oe && $rose(tx_frame_pulse_pin_drive) |->
    $past(tx_bit_clock_pin_drive) && !$past(tx_bit_clock_pin_drive, 2))
    else $error("frame pulse off the rising edge");
  a_gated_nofs: assert property (pins_released[2] |-> !tx_frame_pulse_pin_oe)
    else $error("frame pin driven in gated mode");
  // clock may lead the word by one cycle only, then data must be out
  a_gated_rest: assert property (pins_released[2] && tx_bit_clock_pin_drive && !serial_out_pin_oe |=> serial_out_pin_oe)
    else $error("gated clock runs without a word");
  a_data_edge: assert property (tx_bit_clock_pin_oe && serial_out_pin_oe && $past(serial_out_pin_oe) &&
    $changed(serial_out_pin_drive) |-> $past(tx_bit_clock_pin_drive) && !$past(tx_bit_clock_pin_drive, 2))
    else $error("data changed off the rising edge");

  // main scenarios reached
  c_gated: cover property (pins_released[2] && serial_out_pin_oe);
  c_word: cover property ($rose(serial_out_pin_oe));
  c_rdata: cover property (reg_rdata != 16'h0000);
endmodule : ssp_chk

bind ssp_sync_serial_port ssp_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .tx_bit_clock_pin_drive(tx_bit_clock_pin_drive), .tx_bit_clock_pin_oe(tx_bit_clock_pin_oe),
  .tx_frame_pulse_pin_oe(tx_frame_pulse_pin_oe), .serial_out_pin_drive(serial_out_pin_drive),
  .serial_out_pin_oe(serial_out_pin_oe), .pins_released(pins_released),
  .tx_frame_pulse_pin_drive(tx_frame_pulse_pin_drive));

// ---- verif/ssp_codec.sv ----
`timescale 1ns/1ps

module ssp_codec (
  // resolved pins
  input wire logic pin_sck,
  input wire logic dev_sd,
  input wire logic dev_oe,
  // far side drives
  output logic far_sck,
  output logic far_fs,
  output logic far_sd
);
  logic sending;
  logic bit_v;
  logic junk;
  logic cap[$];

  initial begin
    far_sck = 0;
    far_fs = 0;
    sending = 0;
    bit_v = 0;
    junk = 0;
  end
  // a released line shows a changing level, never a stale bit
  always #37 junk = ~junk;
  // echo the device while it drives, so rx sees its own word
  assign far_sd = sending ? bit_v : (dev_oe ? dev_sd : junk);
  // device bits are taken on the falling clock edge
  always @(negedge pin_sck) cap.push_back(dev_sd);

  // one word: clock only within the burst, bit pulse with first bit
  task automatic send_word(input logic [15:0] w, input int n);
    sending = 1;
    for (int i = 0; i < n + 2; i++) begin
      far_sck = 1;
      far_fs = (i == 0);
      bit_v = (i < n) ? w[15 - i] : ~bit_v;
      #100 far_sck = 0;
      #100;
    end
    sending = 0;
  endtask : send_word
endmodule : ssp_codec

// ---- verif/ssp_sync_serial_port_tb_top.sv ----
`timescale 1ns/1ps
`include "ssp_consts.svh"

module ssp_sync_serial_port_tb_top;
  logic clk = 0;
  logic rst = 1;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  wire [15:0] reg_rdata;
  wire sck_d, sck_oe, fs_d, fs_oe, so_d, so_oe, far_sck, far_fs, far_sd;
  wire [2:0] rel;
  // pin level from whichever side drives it
  wire sck_pin = sck_oe ? sck_d : far_sck;
  wire fs_pin = fs_oe ? fs_d : far_fs;
  int error_cnt = 0;
  int checks = 0;
  logic [15:0] model [int];
  logic [15:0] d, w;

  always #12.5 clk = ~clk;

  ssp_sync_serial_port dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_bit_clock_pin_level(sck_pin),
    .tx_bit_clock_pin_drive(sck_d), .tx_bit_clock_pin_oe(sck_oe), .tx_frame_pulse_pin_level(fs_pin),
    .tx_frame_pulse_pin_drive(fs_d), .tx_frame_pulse_pin_oe(fs_oe), .serial_out_pin_drive(so_d),
    .serial_out_pin_oe(so_oe), .serial_in_pin(far_sd), .pins_released(rel));
  ssp_codec codec (.pin_sck(sck_pin), .dev_sd(so_d), .dev_oe(so_oe), .far_sck(far_sck), .far_fs(far_fs),
    .far_sd(far_sd));

  // ------------------------------------------------
  // bus tasks; a spare edge keeps strobes single-driven
  // ------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1;
    @(posedge clk);
    reg_write <= 0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clk);
    reg_read <= 0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask : rd

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp

  // read a place and compare with the shadow copy
  task automatic chk_reg(input logic [4:0] a);
    logic [15:0] v;
    rd(a, v);
    cmp(v, model.exists(a) ? model[a] : 16'h0000, "register");
  endtask : chk_reg

  task automatic conclude;
    $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // bounded poll of the rx full flag
  task automatic wait_rx;
    d = 0;
    for (int k = 0; k < 2000 && !d[1]; k++) rd(`SSP_OFS_CONTROL_AND_STATUS, d);
    if (!d[1]) begin
      error_cnt++;
      $display("mismatch at %0t: no word received", $time);
      conclude();
    end
  endtask : wait_rx

  // one word through the echoing far side, internal clock
  task automatic xfer(input logic [1:0] wl, input logic lsb, input logic gated);
    int n;
    logic [15:0] s, x;
    n = (wl == 2'h3) ? 16 : 8 + 2 * wl;
    s = 0;
    x = 0;
    w = 16'($urandom);
    // half period of 8 clocks leaves room for the input synchroniser
    wr(`SSP_OFS_SECOND_CONTROL, {8'h07, 7'h00, lsb});
    wr(`SSP_OFS_CONTROL_AND_STATUS, 16'h0100);
    wr(`SSP_OFS_OPTION_CONTROL, 16'h0001);
    wr(`SSP_OFS_RECEIVE_CONTROL, {7'h00, gated, 8'h00});
    codec.cap.delete();
    wr(`SSP_OFS_TRANSMIT_CONTROL, {7'h00, 2'h3, wl, 5'h00});
    wr(`SSP_OFS_TRANSMIT_DATA, w);
    wait_rx();
    cmp({15'h0, rel[2]}, {15'h0, gated}, "gated select");
    rd(`SSP_OFS_RECEIVE_DATA, d);
    cmp(d, w & (16'hffff << (16 - n)), "rx word");
    for (int i = 0; i < n; i++) begin
      s[15 - i] = codec.cap[i];
      x[15 - i] = lsb ? w[16 - n + i] : w[15 - i];
    end
    cmp(s, x, "wire bits");
    wr(`SSP_OFS_RECEIVE_CONTROL, 16'h0000);
    wr(`SSP_OFS_TRANSMIT_CONTROL, 16'h0000);
    $display("test word len %0d lsb %0d gated %0d done", n, lsb, gated);
  endtask : xfer

  initial begin
    reg_addr = 0;
    reg_wdata = 0;
    reg_write = 0;
    reg_read = 0;
    model[4] = 16'h0001;
    void'($urandom(30703));
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    // reset values, write-only, read-only and unmapped places
    for (int a = 0; a < 32; a += 2) chk_reg(a[4:0]);
    for (int a = 14; a < 28; a += 2) begin
      if (a == 18) continue;
      w = 16'($urandom);
      wr(a[4:0], w);
      model[a] = w;
    end
    wr(`SSP_OFS_TIME_SLOT, 16'hffff);
    wr(`SSP_OFS_RECEIVE_DATA, 16'hffff);
    wr(`SSP_OFS_FRAME_STATUS, 16'hffff);
    wr(5'h1e, 16'hffff);
    for (int a = 0; a < 32; a += 2) chk_reg(a[4:0]);
    $display("test registers done");
    for (int m = 0; m < 4; m++) xfer(m[1:0], 1'b0, 1'b0);
    xfer(2'h1, 1'b1, 1'b0);
    xfer(2'h3, 1'b0, 1'b1);
    // far end supplies clock and frame, device only listens
    wr(`SSP_OFS_SECOND_CONTROL, 16'h0000);
    wr(`SSP_OFS_OPTION_CONTROL, 16'h0000);
    wr(`SSP_OFS_TRANSMIT_CONTROL, 16'h00e0);
    w = 16'($urandom);
    codec.send_word(w, 16);
    @(posedge clk);
    wait_rx();
    rd(`SSP_OFS_RECEIVE_DATA, d);
    cmp(d, w, "external word");
    $display("test external clock done");
    conclude();
  end
endmodule : ssp_sync_serial_port_tb_top
